// file: power_wake_event_unit.sv
// Always-on power sequencing, wake event and reset control.
`timescale 1ns/1ps
`default_nettype none

module power_wake_event_unit
    import pwr_wake_pkg::*;
#(
    parameter int unsigned LED_HALF = pwr_wake_pkg::LED_HALF_CYC,
    parameter int unsigned RING_MIN = pwr_wake_pkg::RING_MIN_CYC,
    parameter int unsigned THERMAL_ALARM_N_MIN = pwr_wake_pkg::THERMAL_ALARM_N_MIN_CYC,
    parameter int unsigned RST_HOLD = pwr_wake_pkg::RST_HOLD_CYC
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire pwr_wake_pkg::pins_t pins_i,
    input wire pwr_wake_pkg::pm_cfg_t cfg_i,
    input wire logic sleep_req_i,
    input wire logic deep_sleep_i,
    input wire pwr_wake_pkg::irq_set_t irq_clear_i,
    output logic supply_on_n_o,
    output logic supply_on_oe_o,
    output logic sleep_indicator_led_o,
    output logic sleep_indicator_led_oe_o,
    output logic sci_o,
    output logic mgmt_interrupt_n_o,
    output logic general_event_irq_o,
    output logic nmi_o,
    output logic thermal_override_o,
    output logic throttle_o,
    output logic bus_reset_out_n_o,
    output logic cpu_reset_out_o,
    output pwr_wake_pkg::pwr_state_t power_state_o
);
    import pwr_wake_pkg::*;

    // ----------------------------------------------------------------
    // Parameter checks
    // ----------------------------------------------------------------
    // Every duration must be at least one cycle to be counted.
    if (LED_HALF < 1 || RING_MIN < 1 || THERMAL_ALARM_N_MIN < 1 || RST_HOLD < 1) begin : g_bad
        $error("power_wake_event_unit: durations must be at least one cycle");
    end

    // Saturating step of a duration counter; restarts when inactive.
    function automatic logic [CW-1:0] dur_next(input logic act, input logic [CW-1:0] cnt);
        if (!act) begin
            dur_next = '0;
        end else if (cnt == {CW{1'b1}}) begin
            dur_next = cnt;
        end else begin
            dur_next = cnt + 1'b1;
        end
    endfunction

    // ----------------------------------------------------------------
    // Input synchronisation and edges
    // ----------------------------------------------------------------
    pins_t pin_s;      // Synchronised pin levels.
    pins_t pin_prev_q; // Pin levels one cycle earlier.

    // Every pin passes the synchroniser before any use.
    pin_sync #(
        .W(8),
        .RST_VAL(PINS_IDLE)
    ) u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .async_i(pins_i),
        .level_o(pin_s)
    );

    // Keep the previous level for edge detection.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pin_prev_q <= PINS_IDLE;
        end else begin
            pin_prev_q <= pin_s;
        end
    end

    // Falling edges of the active-low event pins.
    logic button_press;
    logic wake_evt;
    logic ext_evt;
    logic alert_evt;
    logic thermal_alarm_n_evt;
    assign button_press = pin_prev_q.button_n & ~pin_s.button_n;
    assign wake_evt = pin_prev_q.wake_n & ~pin_s.wake_n;
    assign ext_evt = pin_prev_q.ext_n & ~pin_s.ext_n;
    assign alert_evt = pin_prev_q.bus_alert_n & ~pin_s.bus_alert_n;
    assign thermal_alarm_n_evt = pin_prev_q.thermal_alarm_n_n & ~pin_s.thermal_alarm_n_n;

    // ----------------------------------------------------------------
    // Ring and thermal duration checks
    // ----------------------------------------------------------------
    logic [CW-1:0] ring_cnt_q;  // Cycles the ring has been active.
    logic [CW-1:0] thermal_alarm_n_cnt_q; // Cycles the alarm has been active.
    logic ring_long;            // One pulse per long ring.
    logic thermal_alarm_n_long;           // One pulse per long alarm.

    // Counters restart whenever the input goes inactive.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ring_cnt_q <= '0;
            thermal_alarm_n_cnt_q <= '0;
        end else begin
            ring_cnt_q <= dur_next(pin_s.ring, ring_cnt_q);
            thermal_alarm_n_cnt_q <= dur_next(~pin_s.thermal_alarm_n_n, thermal_alarm_n_cnt_q);
        end
    end

    // Report when the count passes the limit, once per assertion.
    assign ring_long = pin_s.ring && (ring_cnt_q == CW'(RING_MIN));
    assign thermal_alarm_n_long = ~pin_s.thermal_alarm_n_n && (thermal_alarm_n_cnt_q == CW'(THERMAL_ALARM_N_MIN));

    // Override pulses once; throttling lasts while the alarm stays on.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            thermal_override_o <= 1'b0;
            throttle_o <= 1'b0;
        end else begin
            thermal_override_o <= thermal_alarm_n_long;
            if (pin_s.thermal_alarm_n_n) begin
                throttle_o <= 1'b0;
            end else if (thermal_alarm_n_long) begin
                throttle_o <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Power state machine
    // ----------------------------------------------------------------
    pwr_state_t state_q;
    logic wake_any;  // Any wake that is allowed in a sleeping state.
    logic sleep_any; // Any request to leave the working state.
    logic ring_wake;
    logic alert_wake;
    logic ext_wake;

    assign ring_wake = ring_long & cfg_i.ring_wake_en;
    assign alert_wake = alert_evt & cfg_i.alert_wake_en;
    assign ext_wake = ext_evt && (cfg_i.ext_mode == EXT_WAKE);
    assign wake_any = button_press | wake_evt | ring_wake | alert_wake | ext_wake;
    assign sleep_any = sleep_req_i | button_press | (ext_evt && (cfg_i.ext_mode == EXT_SLEEP));

    // Move between off, working and sleeping.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= ST_OFF;
        end else begin
            unique case (state_q)
                ST_ON: begin
                    if (sleep_any) begin
                        state_q <= deep_sleep_i ? ST_OFF : ST_SLEEP;
                    end
                end
                ST_SLEEP: begin
                    if (wake_any) begin
                        state_q <= ST_ON;
                    end
                end
                ST_OFF: begin
                    if (wake_any) begin
                        state_q <= ST_ON;
                    end
                end
            endcase
        end
    end

    // Supply is switched on by pulling its open-drain line low.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            supply_on_n_o <= 1'b0;
            supply_on_oe_o <= 1'b0;
            power_state_o <= ST_OFF;
        end else begin
            supply_on_n_o <= 1'b0;
            supply_on_oe_o <= (state_q != ST_OFF) || wake_any;
            power_state_o <= state_q;
        end
    end

    // ----------------------------------------------------------------
    // Sleep indicator blink
    // ----------------------------------------------------------------
    logic [CW-1:0] led_cnt_q; // Cycles into the current half period.
    logic led_blink;

    assign led_blink = cfg_i.led_en && (state_q != ST_ON);

    // Toggle the indicator every half second while asleep.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            led_cnt_q <= '0;
            sleep_indicator_led_o <= 1'b0;
            sleep_indicator_led_oe_o <= 1'b0;
        end else begin
            sleep_indicator_led_o <= 1'b0;
            if (!led_blink) begin
                led_cnt_q <= '0;
                sleep_indicator_led_oe_o <= 1'b0;
            end else if (led_cnt_q == CW'(LED_HALF - 1)) begin
                led_cnt_q <= '0;
                sleep_indicator_led_oe_o <= ~sleep_indicator_led_oe_o;
            end else begin
                led_cnt_q <= led_cnt_q + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Event interrupts
    // ----------------------------------------------------------------
    irq_set_t pend_q; // Pending interrupt lines.
    logic irq_evt;    // Any event that asks for an interrupt.

    assign irq_evt = (ext_evt && (cfg_i.ext_mode == EXT_IRQ))
        || (wake_evt && (state_q == ST_SLEEP))
        || (thermal_alarm_n_evt && cfg_i.thermal_alarm_n_irq_en)
        || (alert_evt && cfg_i.alert_irq_en);

    // Pending lines hold until cleared; a new event beats the clear.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~irq_clear_i) | (irq_evt ? cfg_i.route : 3'h0);
        end
    end

    // Drive the interrupt lines from flops.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sci_o <= 1'b0;
            mgmt_interrupt_n_o <= 1'b1;
            general_event_irq_o <= 1'b0;
        end else begin
            sci_o <= pend_q.sci;
            mgmt_interrupt_n_o <= ~pend_q.smi;
            general_event_irq_o <= pend_q.gpe;
        end
    end

    // Enabled system error drives the NMI line high while low.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            nmi_o <= 1'b0;
        end else begin
            nmi_o <= cfg_i.nmi_en & ~pin_s.serr_n;
        end
    end

    // ----------------------------------------------------------------
    // Bus and processor reset
    // ----------------------------------------------------------------
    logic [CW-1:0] pg_cnt_q; // Cycles since power good rose.
    logic pg_done;

    // Power good is taken as a stable supply once high for RST_HOLD cycles.
    assign pg_done = pin_s.pwr_good && (pg_cnt_q >= CW'(RST_HOLD));

    // Count power good time; low power good restarts the count.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pg_cnt_q <= '0;
        end else begin
            pg_cnt_q <= dur_next(pin_s.pwr_good, pg_cnt_q);
        end
    end

    // Both resets held until power good has lasted the hold time.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bus_reset_out_n_o <= 1'b0;
            cpu_reset_out_o <= 1'b1;
        end else begin
            bus_reset_out_n_o <= pg_done;
            cpu_reset_out_o <= ~pg_done;
        end
    end

endmodule

`default_nettype wire

// file: pwr_wake_pkg.sv
// Shared constants and types for the power wake event unit.
package pwr_wake_pkg;

    // ----------------------------------------------------------------
    // Timing constants
    // ----------------------------------------------------------------
    // Clock rate in kHz, so a figure in ms times this gives cycles.
    localparam int unsigned CLK_KHZ = 100000;
    // Half period of the 1 Hz indicator blink, in ms.
    localparam int unsigned LED_HALF_MS = 500;
    // Least ring pulse length that counts as a wake, in ms.
    localparam int unsigned RING_MIN_MS = 4;
    // Thermal alarm duration that forces an override, in ms (2 s).
    localparam int unsigned THERMAL_ALARM_N_MIN_MS = 2000;
    // Reset hold time after main power good rises, in ms.
    localparam int unsigned RST_HOLD_MS = 24;
    // Cycle counts derived from the times above.
    localparam int unsigned LED_HALF_CYC = LED_HALF_MS * CLK_KHZ;
    localparam int unsigned RING_MIN_CYC = RING_MIN_MS * CLK_KHZ;
    localparam int unsigned THERMAL_ALARM_N_MIN_CYC = THERMAL_ALARM_N_MIN_MS * CLK_KHZ;
    localparam int unsigned RST_HOLD_CYC = RST_HOLD_MS * CLK_KHZ;
    // Width of every duration counter.
    localparam int CW = 32;

    // ----------------------------------------------------------------
    // Pin group and its idle value
    // ----------------------------------------------------------------
    typedef struct packed {
        logic serr_n;      // System error, active low.
        logic pwr_good;    // Main power good, active high.
        logic bus_alert_n; // Management bus alert, active low.
        logic thermal_alarm_n_n;     // Thermal alarm, active low.
        logic ring;        // Ring indicator, active high.
        logic ext_n;       // External event, active low.
        logic wake_n;      // Wake request, active low.
        logic button_n;    // Power button, active low.
    } pins_t;
    // Every pin at its inactive level, power not good.
    localparam logic [7:0] PINS_IDLE = 8'hB7;

    // ----------------------------------------------------------------
    // Configuration and interrupt types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        EXT_WAKE = 2'h0,
        EXT_SLEEP = 2'h1,
        EXT_IRQ = 2'h2,
        EXT_OFF = 2'h3
    } ext_mode_t;

    typedef struct packed {
        logic sci;
        logic smi;
        logic gpe;
    } irq_set_t;

    typedef struct packed {
        ext_mode_t ext_mode; // Use of the external event input.
        irq_set_t route;     // Interrupt lines an event raises.
        logic ring_wake_en;  // Long ring pulse may wake.
        logic alert_wake_en; // Bus alert may wake.
        logic alert_irq_en;  // Bus alert may interrupt.
        logic thermal_alarm_n_irq_en;  // Thermal alarm may interrupt.
        logic nmi_en;        // System error raises NMI.
        logic led_en;        // Indicator blinks while asleep.
    } pm_cfg_t;

    // Power states, one-hot.
    typedef enum logic [2:0] {
        ST_OFF = 3'b001,
        ST_ON = 3'b010,
        ST_SLEEP = 3'b100
    } pwr_state_t;

endpackage

// file: pin_sync.sv
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int W = 8,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] level_o
);

    // Synchroniser stages; the first is read only by the second.
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;

    // Shift the pins through the three stages.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
        end else begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // A bit changes only once the second and third stages agree.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            level_q <= RST_VAL;
        end else begin
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign level_o = level_q;

endmodule

`default_nettype wire

// file: power_wake_event_unit_monitor.sv
// Port-level concurrent checks for the power wake event unit.
`timescale 1ns/1ps
`default_nettype none

module power_wake_monitor
    import pwr_wake_pkg::*;
#(
    parameter int unsigned LED_HALF = 8,
    parameter int unsigned THERMAL_ALARM_N_MIN = 8,
    parameter int unsigned RST_HOLD = 8
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire pwr_wake_pkg::pins_t pins_i,
    input wire pwr_wake_pkg::pm_cfg_t cfg_i,
    input wire logic supply_on_oe_o,
    input wire logic sleep_indicator_led_oe_o,
    input wire logic mgmt_interrupt_n_o,
    input wire logic nmi_o,
    input wire logic thermal_override_o,
    input wire logic throttle_o,
    input wire logic bus_reset_out_n_o,
    input wire logic cpu_reset_out_o,
    input wire pwr_wake_pkg::pwr_state_t power_state_o
);
    logic [31:0] pg_q; // Cycles power good has been high at the pin.
    logic [31:0] hot_q; // Cycles the alarm has been low at the pin.
    logic [31:0] gap_q; // Cycles since the indicator enable last changed.
    logic seen_q; // A blink fall happened outside the working state.

    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);

    // Run lengths at the pins, restarted when the level goes away.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pg_q <= 32'h0;
            hot_q <= 32'h0;
        end else begin
            pg_q <= pins_i.pwr_good ? pg_q + 32'h1 : 32'h0;
            hot_q <= pins_i.thermal_alarm_n_n ? 32'h0 : hot_q + 32'h1;
        end
    end

    // Spacing between indicator changes.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gap_q <= 32'h0;
        end else begin
            gap_q <= $changed(sleep_indicator_led_oe_o) ? 32'h1 : gap_q + 32'h1;
        end
    end

    // Only a rise that follows a blink fall measures a full half period.
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            seen_q <= 1'b0;
        end else if (power_state_o == ST_ON) begin
            seen_q <= 1'b0;
        end else if ($fell(sleep_indicator_led_oe_o)) begin
            seen_q <= 1'b1;
        end
    end

    reset_hold_a: assert property ((!pins_i.pwr_good) [*8] |-> !bus_reset_out_n_o)
        else $error("bus reset released while power good low");
    release_time_a: assert property ($rose(bus_reset_out_n_o) |-> pg_q >= RST_HOLD)
        else $error("bus reset released too early");
    release_late_a: assert property (pg_q == RST_HOLD + 8 |-> bus_reset_out_n_o)
        else $error("bus reset held too long");
    reset_pair_a: assert property (cpu_reset_out_o != bus_reset_out_n_o)
        else $error("cpu reset out of step with bus reset");
    nmi_set_a: assert property ((cfg_i.nmi_en && !pins_i.serr_n) [*7] |-> nmi_o)
        else $error("system error gave no nmi");
    nmi_clear_a: assert property ((pins_i.serr_n) [*7] |-> !nmi_o)
        else $error("nmi without system error");
    ovr_time_a: assert property ($rose(thermal_override_o) |-> hot_q >= THERMAL_ALARM_N_MIN)
        else $error("thermal override too early");
    ovr_pulse_a: assert property (thermal_override_o |=> !thermal_override_o && throttle_o)
        else $error("override not a single pulse with throttle");
    wake_supply_a: assert property (power_state_o == ST_OFF && $fell(pins_i.wake_n)
        |-> ##[1:8] supply_on_oe_o) else $error("wake request left supply off");
    wake_irq_a: assert property (power_state_o == ST_SLEEP && cfg_i.route.smi
        && $fell(pins_i.wake_n) |-> ##[2:10] !mgmt_interrupt_n_o)
        else $error("wake from suspend gave no interrupt");
    blink_rate_a: assert property ($rose(sleep_indicator_led_oe_o) && seen_q
        |-> gap_q == LED_HALF) else $error("indicator half period wrong");

    cover property (thermal_override_o);
    cover property ($rose(bus_reset_out_n_o));
    cover property ($rose(sleep_indicator_led_oe_o) && seen_q);
endmodule

bind power_wake_event_unit power_wake_monitor #(
    .LED_HALF(LED_HALF), .THERMAL_ALARM_N_MIN(THERMAL_ALARM_N_MIN), .RST_HOLD(RST_HOLD)
) mon_u (
    .clk_i(clk_i), .nrst_i(nrst_i), .pins_i(pins_i), .cfg_i(cfg_i),
    .supply_on_oe_o(supply_on_oe_o), .sleep_indicator_led_oe_o(sleep_indicator_led_oe_o),
    .mgmt_interrupt_n_o(mgmt_interrupt_n_o), .nmi_o(nmi_o),
    .thermal_override_o(thermal_override_o), .throttle_o(throttle_o),
    .bus_reset_out_n_o(bus_reset_out_n_o), .cpu_reset_out_o(cpu_reset_out_o),
    .power_state_o(power_state_o)
);
`default_nettype wire

// file: supply_model.sv
// Switched power supply that reports power good once its rail settles.
`timescale 1ns/1ps
`default_nettype none

module supply_model #(
    parameter int DLY = 5
) (
    input wire logic clk_i,
    input wire logic supply_on_n_i,
    input wire logic supply_on_oe_i,
    output logic pwr_good_o
);
    wire logic on_line = supply_on_oe_i ? supply_on_n_i : 1'b1; // Pulled up when released.
    int cnt = 0; // Cycles the rail has been switched on.
    logic good_q = 1'b0; // Rail settled, starts low at power up.

    // Power good only after the rail has been on for DLY cycles.
    always @(posedge clk_i) begin
        cnt <= on_line ? 0 : ((cnt < DLY) ? cnt + 1 : cnt);
        good_q <= !on_line && cnt >= DLY;
    end

    assign pwr_good_o = good_q;
endmodule
`default_nettype wire

// file: power_wake_event_unit_test.sv
// Self-checking bench for the power wake event unit.
`timescale 1ns/1ps
`default_nettype none

module power_wake_event_unit_test;
    import pwr_wake_pkg::*;
    localparam int LH = 12;
    localparam int RM = 10;
    localparam int TM = 20;
    localparam int RH = 16;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] pv = PINS_IDLE; // Pin levels, power good slot unused.
    logic pg; // Power good from the supply model.
    pins_t pins_i;
    pm_cfg_t cfg_i = {EXT_OFF, 3'h7, 6'h37};
    logic sleep_req_i = 1'b0;
    logic deep_sleep_i = 1'b0;
    irq_set_t irq_clear_i = 3'h0;
    logic son_n, son_oe, led_n, led_oe, sci, smi_n, gpe, nmi, ovr, thr, brst_n, crst;
    pwr_state_t st;
    logic [5:0] ob; // Outputs that the bench waits on.
    int num_errors = 0;
    int samples_checked = 0;

    assign pins_i = {pv[7], pg, pv[5:0]};
    assign ob = {nmi, thr, ovr, led_oe, brst_n, pg};
    always #5 clk_i = ~clk_i;

    supply_model #(.DLY(5)) psu (.clk_i(clk_i), .supply_on_n_i(son_n),
        .supply_on_oe_i(son_oe), .pwr_good_o(pg));
    power_wake_event_unit #(.LED_HALF(LH), .RING_MIN(RM), .THERMAL_ALARM_N_MIN(TM), .RST_HOLD(RH)) dut (
        .clk_i(clk_i), .nrst_i(nrst_i), .pins_i(pins_i), .cfg_i(cfg_i),
        .sleep_req_i(sleep_req_i), .deep_sleep_i(deep_sleep_i), .irq_clear_i(irq_clear_i),
        .supply_on_n_o(son_n), .supply_on_oe_o(son_oe), .sleep_indicator_led_o(led_n),
        .sleep_indicator_led_oe_o(led_oe), .sci_o(sci), .mgmt_interrupt_n_o(smi_n),
        .general_event_irq_o(gpe), .nmi_o(nmi), .thermal_override_o(ovr), .throttle_o(thr),
        .bus_reset_out_n_o(brst_n), .cpu_reset_out_o(crst), .power_state_o(st));

    // --------------------------------
    // Helpers
    // --------------------------------
    task automatic tally_and_finish;
        $display("Checks %0d, errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // Invert one pin for n cycles, then restore it.
    task automatic hit(input int b, input int n);
        @(posedge clk_i);
        pv[b] <= ~pv[b];
        cyc(n);
        pv[b] <= ~pv[b];
    endtask

    // Bounded wait for a power state; a timeout ends the run.
    task automatic go(input pwr_state_t s);
        int i;
        for (i = 0; i < 99 && st !== s; i++) @(posedge clk_i);
        chk(st, s);
        if (st !== s) tally_and_finish();
    endtask

    // Bounded wait for one watched output, n counts the cycles.
    task automatic wt(input int k, input logic v, output int n);
        for (n = 0; n < 300 && ob[k] !== v; n++) @(posedge clk_i);
        if (ob[k] !== v) begin
            chk(ob[k], v);
            tally_and_finish();
        end
    endtask

    // Check the interrupt lines, then clear them.
    task automatic irqs(input logic [2:0] e);
        cyc(4);
        chk({sci, smi_n, gpe}, e);
        irq_clear_i <= 3'h7;
        cyc(1);
        irq_clear_i <= 3'h0;
        cyc(2);
        chk({sci, smi_n, gpe}, 3'h2);
    endtask

    task automatic sleep(input logic d);
        @(posedge clk_i);
        deep_sleep_i <= d;
        sleep_req_i <= 1'b1;
        go(d ? ST_OFF : ST_SLEEP);
        sleep_req_i <= 1'b0;
    endtask

    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic s_boot;
        int n;
        chk({brst_n, crst, son_oe}, 3'h2);
        chk({son_n, led_n}, 2'h0);
        hit(1, 6);
        go(ST_ON);
        chk(son_oe, 1'b1);
        wt(0, 1'b1, n);
        wt(1, 1'b1, n);
        chk(8'(n >= RH && n <= RH + 8), 8'h1);
        chk(crst, 1'b0);
    endtask

    task automatic s_blink;
        int n;
        hit(0, 6);
        go(ST_SLEEP);
        wt(2, 1'b1, n);
        wt(2, 1'b0, n);
        chk(n[7:0], 8'(LH));
        hit(0, 6);
        go(ST_ON);
    endtask

    // Two short rings must not add up; a long one wakes.
    task automatic s_ring;
        sleep(1'b0);
        hit(3, RM - 4);
        cyc(6);
        hit(3, RM - 4);
        cyc(20);
        chk(st, ST_SLEEP);
        hit(3, RM + 6);
        go(ST_ON);
    endtask

    task automatic s_ext;
        sleep(1'b0);
        hit(1, 6);
        go(ST_ON);
        irqs(3'h5);
        cfg_i.ext_mode <= EXT_IRQ;
        hit(2, 6);
        irqs(3'h5);
        cfg_i.ext_mode <= EXT_OFF;
        hit(2, 6);
        irqs(3'h2);
        chk(st, ST_ON);
        cfg_i.ext_mode <= EXT_SLEEP;
        hit(2, 6);
        go(ST_SLEEP);
        cfg_i.ext_mode <= EXT_WAKE;
        hit(2, 6);
        go(ST_ON);
        cfg_i.ext_mode <= EXT_OFF;
    endtask

    task automatic s_thermal_alarm_n;
        int n;
        @(posedge clk_i);
        pv[4] <= 1'b0;
        wt(3, 1'b1, n);
        chk(8'(n >= TM && n <= TM + 8), 8'h1);
        wt(3, 1'b0, n);
        chk(n[7:0], 8'h1);
        chk(thr, 1'b1);
        irqs(3'h5);
        pv[4] <= 1'b1;
        wt(4, 1'b0, n);
    endtask

    task automatic s_alert;
        sleep(1'b0);
        hit(5, 6);
        go(ST_ON);
        cfg_i.alert_irq_en <= 1'b1;
        hit(5, 6);
        irqs(3'h5);
    endtask

    task automatic s_nmi;
        int n;
        @(posedge clk_i);
        pv[7] <= 1'b0;
        wt(5, 1'b1, n);
        chk(8'(n <= 8), 8'h1);
        cfg_i.nmi_en <= 1'b0;
        wt(5, 1'b0, n);
        chk(8'(n <= 4), 8'h1);
        pv[7] <= 1'b1;
    endtask

    // Power off drops power good, which must reassert both resets.
    task automatic s_off;
        int n;
        sleep(1'b1);
        wt(1, 1'b0, n);
        chk({son_oe, brst_n, crst}, 3'h1);
        hit(0, 6);
        go(ST_ON);
        wt(1, 1'b1, n);
    endtask

    initial begin
        cyc(2);
        nrst_i <= 1'b1;
        cyc(2);
        s_boot();
        s_blink();
        s_ring();
        s_ext();
        s_thermal_alarm_n();
        s_alert();
        s_nmi();
        s_off();
        tally_and_finish();
    end
endmodule
`default_nettype wire
